/* inc/sensor_regs_pkg.sv */
/*
   Constants for the readout-mode, flash-strobe and channel-gain register slice.
   Assumes an 8-bit register index and 16-bit register data from the serial port.
*/
// Operation
// - Context A low-power bit halves readout rate; zero reads at full speed.
// - Context A column skip: read two columns, skip two, repeatedly.
// - Context A row skip: read two rows, skip two, e.g. 8, 9, 12, 13.
// - Context selector: zero applies context A fields, one applies context B fields.
// - Flash control top bit is read-only and shows the strobe output state.
// - Xenon flash drives strobe high for the programmed length inside vertical blanking.
// - Xenon mode holds integration at one frame; pulse stays shorter than blanking.
// - Flash pulse is postponed by the two-bit frame delay count.
// - Xenon fires after readout when end-of-reset is zero, after reset when one.
// - Xenon flash fires for one frame only, or every frame when every-frame is set; with a frame delay of N it fires every N+1 frames.
// - LED flash raises strobe before the frame reset starts.
// - LED disabled: strobe stays high until current frame readout completes.
// - Xenon pulse length is count times 1024 clock cycles; count defaults to eight.
// - Initial gain is seven-bit field times 0.03125; default 0x20 is unity.
// - Each set analog gain bit doubles the initial gain.
// - Each set digital gain bit doubles the analog gain.
package sensor_regs_pkg;
   // ***************************************************************
   // Register indices
   // ***************************************************************
   localparam logic [7:0] READOUT_MODE_CTX_A_IDX = 8'h21;
   localparam logic [7:0] FLASH_STROBE_CONTROL_IDX = 8'h23;
   localparam logic [7:0] FIRST_GREEN_CHANNEL_GAIN_IDX = 8'h2b;
   localparam logic [7:0] BLUE_CHANNEL_GAIN_IDX = 8'h2c;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int LOW_POWER_BIT = 10;
   localparam int COL_SKIP_BIT = 3;
   localparam int ROW_SKIP_BIT = 2;
   localparam int FLASH_STROBE_BIT = 15;
   localparam int XENON_EN_BIT = 13;
   localparam int FRAME_DELAY_LSB = 11;
   localparam int END_OF_RESET_BIT = 10;
   localparam int EVERY_FRAME_BIT = 9;
   localparam int LED_EN_BIT = 8;
   localparam int XENON_COUNT_LSB = 0;
   localparam int INIT_GAIN_LSB = 0;
   localparam int ANALOG_GAIN_LSB = 7;
   localparam int DIGITAL_GAIN_LSB = 9;
   localparam int SKIP_PAIR_BIT = 1;

   // ***************************************************************
   // Reset values and writable masks
   // ***************************************************************
   localparam logic [15:0] READOUT_MODE_RESET = 16'h040c;
   localparam logic [15:0] READOUT_MODE_MASK = 16'h040c;
   localparam logic [15:0] FLASH_CONTROL_RESET = 16'h0608;
   localparam logic [15:0] FLASH_CONTROL_MASK = 16'h3fff;
   localparam logic [15:0] GAIN_RESET = 16'h0020;
   localparam logic [15:0] GAIN_MASK = 16'h07ff;

   // ***************************************************************
   // Timing and gain format
   // ***************************************************************
   localparam int XENON_UNIT_CYCLES = 1024;
   localparam int GAIN_FRAC_BITS = 5;
   localparam int GAIN_FIELD_W = 11;
   localparam int ANALOG_OUT_W = 9;
   localparam int TOTAL_OUT_W = 11;

   typedef enum {
      FL_IDLE,
      FL_DELAY,
      FL_WAIT,
      FL_PULSE,
      FL_LED,
      FL_LED_HOLD,
      FL_SPENT
   } flash_state_t;
endpackage

/* rtl/frame_shadow.sv */
/*
   Shadow register: holds a pending value and applies it on a frame-start pulse.
   Assumes frameStart is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_shadow #(
   parameter int W = 8,
   parameter logic [W-1:0] RESET_VALUE = '0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic frameStart,
   input wire logic [W-1:0] pending,
   output logic [W-1:0] applied
);
   logic [W-1:0] next_applied;

   always_comb
   begin
      next_applied = applied;
      if (frameStart)
      begin
         next_applied = pending;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         applied <= RESET_VALUE;
      end
      else if (ce)
      begin
         applied <= next_applied;
      end
   end
endmodule
`default_nettype wire

/* rtl/sensor_readmode_flash_gain_regs.sv */
/*
   Context-A readout options, flash strobe controller and green1/blue gains.
   Assumes the serial interface presents one-cycle register read/write strobes,
   and that frame timing events arrive as one-cycle pulses synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_readmode_flash_gain_regs
   import sensor_regs_pkg::*;
#(
   parameter int PULSE_UNIT = sensor_regs_pkg::XENON_UNIT_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   output logic regAck,
   input wire logic contextB,
   input wire logic ctxBLowPower,
   input wire logic ctxBColSkip,
   input wire logic ctxBRowSkip,
   input wire logic frameStart,
   input wire logic resetDone,
   input wire logic readoutDone,
   input wire logic vblank,
   input wire logic [10:0] rowIndex,
   input wire logic [10:0] colIndex,
   output logic lowPowerReadout,
   output logic readoutTick,
   output logic rowKeep,
   output logic colKeep,
   output logic flashStrobe,
   output logic holdOneFrameIntegration,
   output logic [sensor_regs_pkg::ANALOG_OUT_W-1:0] green1AnalogGain,
   output logic [sensor_regs_pkg::TOTAL_OUT_W-1:0] green1TotalGain,
   output logic [sensor_regs_pkg::ANALOG_OUT_W-1:0] blueAnalogGain,
   output logic [sensor_regs_pkg::TOTAL_OUT_W-1:0] blueTotalGain
);
   import sensor_regs_pkg::*;

   localparam int CNT_W = 8 + $clog2(PULSE_UNIT) + 1;
   localparam logic [CNT_W-1:0] UNIT_W = CNT_W'(PULSE_UNIT);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam int SHADOW_W = 3 + 2 + 2 * GAIN_FIELD_W;
   localparam logic [SHADOW_W-1:0] SHADOW_RESET =
      {1'b1, 1'b1, 1'b1, 1'b0, 1'b0, GAIN_RESET[GAIN_FIELD_W-1:0], GAIN_RESET[GAIN_FIELD_W-1:0]};

   // ***************************************************************
   // Gain arithmetic
   // ***************************************************************
   function automatic logic [TOTAL_OUT_W-1:0] channelGain(
      input logic [GAIN_FIELD_W-1:0] field,
      input logic withDigital
   );
      logic [TOTAL_OUT_W-1:0] g;
      g = {4'h0, field[INIT_GAIN_LSB +: 7]};
      if (field[ANALOG_GAIN_LSB])
         g = g << 1;
      if (field[ANALOG_GAIN_LSB + 1])
         g = g << 1;
      if (withDigital && field[DIGITAL_GAIN_LSB])
         g = g << 1;
      if (withDigital && field[DIGITAL_GAIN_LSB + 1])
         g = g << 1;
      return g;
   endfunction

   // ***************************************************************
   // Register file
   // ***************************************************************
   logic [15:0] readoutMode;
   logic [15:0] flashControl;
   logic [15:0] green1Gain;
   logic [15:0] blueGain;
   logic [15:0] next_readoutMode;
   logic [15:0] next_flashControl;
   logic [15:0] next_green1Gain;
   logic [15:0] next_blueGain;
   logic [15:0] next_regRdata;
   logic next_regAck;

   always_comb
   begin
      next_readoutMode = readoutMode;
      next_flashControl = flashControl;
      next_green1Gain = green1Gain;
      next_blueGain = blueGain;
      if (regWrite)
      begin
         if (regAddr == READOUT_MODE_CTX_A_IDX)
            next_readoutMode = regWdata & READOUT_MODE_MASK;
         else if (regAddr == FLASH_STROBE_CONTROL_IDX)
            // Strobe status bit is not writable
            next_flashControl = regWdata & FLASH_CONTROL_MASK;
         else if (regAddr == FIRST_GREEN_CHANNEL_GAIN_IDX)
            next_green1Gain = regWdata & GAIN_MASK;
         else if (regAddr == BLUE_CHANNEL_GAIN_IDX)
            next_blueGain = regWdata & GAIN_MASK;
      end
      next_regAck = regRead;
      next_regRdata = regRdata;
      if (regRead)
      begin
         if (regAddr == READOUT_MODE_CTX_A_IDX)
            next_regRdata = readoutMode;
         else if (regAddr == FLASH_STROBE_CONTROL_IDX)
         begin
            next_regRdata = flashControl;
            next_regRdata[FLASH_STROBE_BIT] = flashStrobe;
         end
         else if (regAddr == FIRST_GREEN_CHANNEL_GAIN_IDX)
            next_regRdata = green1Gain;
         else if (regAddr == BLUE_CHANNEL_GAIN_IDX)
            next_regRdata = blueGain;
         else
            next_regRdata = 16'h0000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         readoutMode <= READOUT_MODE_RESET;
         flashControl <= FLASH_CONTROL_RESET;
         green1Gain <= GAIN_RESET;
         blueGain <= GAIN_RESET;
         regRdata <= 16'h0000;
         regAck <= 1'b0;
      end
      else if (ce)
      begin
         readoutMode <= next_readoutMode;
         flashControl <= next_flashControl;
         green1Gain <= next_green1Gain;
         blueGain <= next_blueGain;
         regRdata <= next_regRdata;
         regAck <= next_regAck;
      end
   end

   // ***************************************************************
   // Frame-synchronised copies
   // ***************************************************************
   logic [SHADOW_W-1:0] shadowPending;
   logic [SHADOW_W-1:0] shadowApplied;
   logic aLowPower;
   logic aColSkip;
   logic aRowSkip;
   logic xenonOn;
   logic ledOn;
   logic [GAIN_FIELD_W-1:0] green1Applied;
   logic [GAIN_FIELD_W-1:0] blueApplied;

   assign shadowPending = {readoutMode[LOW_POWER_BIT], readoutMode[COL_SKIP_BIT],
      readoutMode[ROW_SKIP_BIT], flashControl[XENON_EN_BIT], flashControl[LED_EN_BIT],
      green1Gain[GAIN_FIELD_W-1:0], blueGain[GAIN_FIELD_W-1:0]};
   assign {aLowPower, aColSkip, aRowSkip, xenonOn, ledOn, green1Applied, blueApplied} =
      shadowApplied;

   frame_shadow #(
      .W(SHADOW_W),
      .RESET_VALUE(SHADOW_RESET)
   ) shadowRegs (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .frameStart(frameStart),
      .pending(shadowPending),
      .applied(shadowApplied)
   );

   // ***************************************************************
   // Flash strobe controller
   // ***************************************************************
   flash_state_t flashState;
   flash_state_t next_flashState;
   logic [1:0] delayCnt;
   logic [1:0] next_delayCnt;
   logic [CNT_W-1:0] pulseCnt;
   logic [CNT_W-1:0] next_pulseCnt;
   logic ledMode;
   logic next_ledMode;
   logic next_flashStrobe;
   logic trigEvent;
   logic [7:0] xenonCount;

   assign xenonCount = flashControl[XENON_COUNT_LSB +: 8];
   // Trigger point follows the end-of-reset selection
   assign trigEvent = flashControl[END_OF_RESET_BIT] ? resetDone : readoutDone;

   always_comb
   begin
      next_flashState = flashState;
      next_delayCnt = delayCnt;
      next_pulseCnt = pulseCnt;
      next_ledMode = ledMode;
      case (flashState)
         FL_IDLE:
         begin
            if (frameStart && (ledOn || xenonOn))
            begin
               next_ledMode = ledOn;
               next_delayCnt = flashControl[FRAME_DELAY_LSB +: 2];
               next_flashState = FL_DELAY;
            end
         end
         FL_DELAY:
         begin
            if (!(ledMode ? ledOn : xenonOn))
               next_flashState = FL_IDLE;
            else if (delayCnt == 2'd0)
               // LED lights ahead of the frame reset
               next_flashState = ledMode ? FL_LED : FL_WAIT;
            else if (frameStart)
               next_delayCnt = delayCnt - 2'd1;
         end
         FL_WAIT:
         begin
            if (!xenonOn)
               next_flashState = FL_IDLE;
            else if (trigEvent && vblank)
            begin
               next_pulseCnt = CNT_W'(xenonCount) * UNIT_W;
               if (xenonCount == 8'h00)
                  next_flashState = flashControl[EVERY_FRAME_BIT] ? FL_IDLE : FL_SPENT;
               else
                  next_flashState = FL_PULSE;
            end
         end
         FL_PULSE:
         begin
            next_pulseCnt = pulseCnt - CNT_ONE;
            // Pulse is cut at the end of blanking so every row sees it
            if (pulseCnt == CNT_ONE || !vblank)
               next_flashState = flashControl[EVERY_FRAME_BIT] ? FL_IDLE : FL_SPENT;
         end
         FL_LED:
            if (!ledOn)
               next_flashState = FL_LED_HOLD;
         FL_LED_HOLD:
            if (readoutDone)
               next_flashState = FL_IDLE;
         FL_SPENT:
            // Single-shot mode rearms only after the flash is switched off
            if (!xenonOn && !ledOn)
               next_flashState = FL_IDLE;
         default:
            next_flashState = FL_IDLE;
      endcase
      next_flashStrobe = (next_flashState == FL_PULSE) || (next_flashState == FL_LED) ||
         (next_flashState == FL_LED_HOLD);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         flashState <= FL_IDLE;
         delayCnt <= 2'd0;
         pulseCnt <= '0;
         ledMode <= 1'b0;
         flashStrobe <= 1'b0;
      end
      else if (ce)
      begin
         flashState <= next_flashState;
         delayCnt <= next_delayCnt;
         pulseCnt <= next_pulseCnt;
         ledMode <= next_ledMode;
         flashStrobe <= next_flashStrobe;
      end
   end

   // ***************************************************************
   // Readout control and gain outputs
   // ***************************************************************
   logic effLowPower;
   logic effColSkip;
   logic effRowSkip;
   logic next_lowPowerReadout;
   logic next_readoutTick;
   logic next_rowKeep;
   logic next_colKeep;
   logic next_holdOneFrameIntegration;
   logic [TOTAL_OUT_W-1:0] g1Analog;
   logic [TOTAL_OUT_W-1:0] bAnalog;

   assign effLowPower = contextB ? ctxBLowPower : aLowPower;
   assign effColSkip = contextB ? ctxBColSkip : aColSkip;
   assign effRowSkip = contextB ? ctxBRowSkip : aRowSkip;
   assign g1Analog = channelGain(green1Applied, 1'b0);
   assign bAnalog = channelGain(blueApplied, 1'b0);

   always_comb
   begin
      next_lowPowerReadout = effLowPower;
      next_readoutTick = effLowPower ? ~readoutTick : 1'b1;
      next_colKeep = !effColSkip || !colIndex[SKIP_PAIR_BIT];
      next_rowKeep = !effRowSkip || !rowIndex[SKIP_PAIR_BIT];
      next_holdOneFrameIntegration = xenonOn;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         lowPowerReadout <= 1'b0;
         readoutTick <= 1'b0;
         rowKeep <= 1'b1;
         colKeep <= 1'b1;
         holdOneFrameIntegration <= 1'b0;
         green1AnalogGain <= '0;
         green1TotalGain <= '0;
         blueAnalogGain <= '0;
         blueTotalGain <= '0;
      end
      else if (ce)
      begin
         lowPowerReadout <= next_lowPowerReadout;
         readoutTick <= next_readoutTick;
         rowKeep <= next_rowKeep;
         colKeep <= next_colKeep;
         holdOneFrameIntegration <= next_holdOneFrameIntegration;
         green1AnalogGain <= g1Analog[ANALOG_OUT_W-1:0];
         green1TotalGain <= channelGain(green1Applied, 1'b1);
         blueAnalogGain <= bAnalog[ANALOG_OUT_W-1:0];
         blueTotalGain <= channelGain(blueApplied, 1'b1);
      end
   end
endmodule
`default_nettype wire

/* verif/regs_slice_assertions.sv */
/*
   Port checks for the readout, flash and gain register slice.
   Assumes it is bound to the top module and that ce stays high in use.
*/
`timescale 1ns/1ps
`default_nettype none
module regs_slice_assertions
   import sensor_regs_pkg::*;
#(
   parameter int PULSE_UNIT = sensor_regs_pkg::XENON_UNIT_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic regRead,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regRdata,
   input wire logic regAck,
   input wire logic frameStart,
   input wire logic resetDone,
   input wire logic readoutDone,
   input wire logic vblank,
   input wire logic [10:0] rowIndex,
   input wire logic [10:0] colIndex,
   input wire logic lowPowerReadout,
   input wire logic readoutTick,
   input wire logic rowKeep,
   input wire logic colKeep,
   input wire logic flashStrobe,
   input wire logic [sensor_regs_pkg::TOTAL_OUT_W-1:0] green1TotalGain,
   input wire logic [sensor_regs_pkg::TOTAL_OUT_W-1:0] blueTotalGain
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   a_read_acked:
      assert property (ce && regRead |=> regAck)
      else $error("read not acknowledged");
   a_live_strobe_bit:
      assert property (regAck && $past(regAddr == FLASH_STROBE_CONTROL_IDX)
         |-> regRdata[15:14] == {$past(flashStrobe), 1'b0})
      else $error("flash status bit wrong");
   a_mode_unused_zero:
      assert property (regAck && $past(regAddr == READOUT_MODE_CTX_A_IDX)
         |-> (regRdata & ~READOUT_MODE_MASK) == 16'h0000)
      else $error("unused readout bits set");
   a_full_rate_tick:
      assert property (!lowPowerReadout && $past(!lowPowerReadout) && !$past(srst) |-> readoutTick)
      else $error("full power tick not constant");
   a_half_rate_tick:
      assert property (lowPowerReadout && $past(lowPowerReadout) && !$past(srst)
         |-> readoutTick != $past(readoutTick))
      else $error("low power tick not toggling");
   a_row_kept:
      assert property (ce && !rowIndex[1] |=> rowKeep)
      else $error("row skipped wrongly");
   a_col_kept:
      assert property (ce && !colIndex[1] |=> colKeep)
      else $error("column skipped wrongly");
   a_strobe_cause:
      assert property ($rose(flashStrobe) |-> $past(frameStart) || $past(frameStart, 2)
         || $past((resetDone || readoutDone) && vblank))
      else $error("strobe rose without cause");
   a_gain_frame_sync:
      assert property (!$past(srst) && !$past(srst, 2) && !$past(frameStart)
         && !$past(frameStart, 2) |-> $stable(green1TotalGain) && $stable(blueTotalGain))
      else $error("gain changed mid frame");
   c_strobe_read: cover property (regAck && regRdata[15]);
   c_strobe_vblank: cover property ($rose(flashStrobe) && vblank);
   c_low_to_full: cover property (lowPowerReadout ##1 !lowPowerReadout);
endmodule
bind sensor_readmode_flash_gain_regs regs_slice_assertions #(.PULSE_UNIT(PULSE_UNIT))
   regs_slice_assertions_i (.clk(clk), .srst(srst), .ce(ce), .regRead(regRead),
   .regAddr(regAddr), .regRdata(regRdata), .regAck(regAck), .frameStart(frameStart),
   .resetDone(resetDone), .readoutDone(readoutDone), .vblank(vblank), .rowIndex(rowIndex),
   .colIndex(colIndex), .lowPowerReadout(lowPowerReadout), .readoutTick(readoutTick),
   .rowKeep(rowKeep), .colKeep(colKeep), .flashStrobe(flashStrobe),
   .green1TotalGain(green1TotalGain), .blueTotalGain(blueTotalGain));
`default_nettype wire

/* verif/flash_unit_model.sv */
/*
   Flash unit on the strobe line: counts pulses and keeps the last width.
   Assumes the strobe is sampled on the block clock.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_unit_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic strobe,
   output var int pulses,
   output var int lastWidth
);
   int width;
   always @(posedge clk)
   begin
      if (srst)
      begin
         pulses <= 0;
         lastWidth <= 0;
         width <= 0;
      end
      else if (strobe)
         width <= width + 1;
      else if (width > 0)
      begin
         pulses <= pulses + 1;
         lastWidth <= width;
         width <= 0;
      end
   end
endmodule
`default_nettype wire

/* verif/sensor_readmode_flash_gain_regs_test.sv */
/*
   Self-checking bench for the readout, flash and gain register slice.
   Assumes the design package is compiled first; the flash model watches the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_readmode_flash_gain_regs_test;
   import sensor_regs_pkg::*;
   localparam int UNIT = 4;
   localparam int W = 16;
   logic clk = 0, srst = 1, ce = 1, regWrite = 0, regRead = 0, regAck;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWdata = 16'h0000, regRdata;
   logic contextB = 0, ctxBLowPower = 0, ctxBColSkip = 0, ctxBRowSkip = 0;
   logic frameStart = 0, resetDone = 0, readoutDone = 0, vblank = 0;
   logic [10:0] rowIndex = 11'h000, colIndex = 11'h000, gT, bT;
   logic [8:0] gA, bA;
   logic lowPower, tick, rowKeep, colKeep, strobe, holdOne, p0, p1, p2;
   int errors = 0, comparisons = 0, pulses, lastWidth;

   sensor_readmode_flash_gain_regs #(.PULSE_UNIT(UNIT)) sensor_readmode_flash_gain_regs_i (
      .clk(clk), .srst(srst), .ce(ce), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regAck(regAck),
      .contextB(contextB), .ctxBLowPower(ctxBLowPower), .ctxBColSkip(ctxBColSkip),
      .ctxBRowSkip(ctxBRowSkip), .frameStart(frameStart), .resetDone(resetDone),
      .readoutDone(readoutDone), .vblank(vblank), .rowIndex(rowIndex), .colIndex(colIndex),
      .lowPowerReadout(lowPower), .readoutTick(tick), .rowKeep(rowKeep), .colKeep(colKeep),
      .flashStrobe(strobe), .holdOneFrameIntegration(holdOne), .green1AnalogGain(gA),
      .green1TotalGain(gT), .blueAnalogGain(bA), .blueTotalGain(bT));
   flash_unit_model flash_unit_model_i (.clk(clk), .srst(srst), .strobe(strobe),
      .pulses(pulses), .lastWidth(lastWidth));

   always #2 clk = ~clk;

   task automatic wrap_up;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic note(input logic ok, input string what);
      comparisons++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      note(got === exp, $sformatf("value %h expected %h", got, exp));
   endtask
   task automatic chkBit(input logic got, input logic exp);
      note(got === exp, "output level");
   endtask
   task automatic chkNum(input int got, input int exp);
      note(got == exp, $sformatf("count %0d expected %0d", got, exp));
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
      regWrite = 1;
      regAddr = a;
      regWdata = d;
      step(1);
      regWrite = 0;
      step(1);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [15:0] exp);
      int n;
      regRead = 1;
      regAddr = a;
      step(1);
      regRead = 0;
      for (n = 0; n < 4 && regAck !== 1'b1; n++)
         step(1);
      if (n == 4)
      begin
         errors++;
         wrap_up();
      end
      chk(regRdata, exp);
      step(1);
   endtask
   // Frame: start, readout end and reset end inside blanking, strobe sampled after each
   task automatic frame;
      frameStart = 1;
      step(1);
      frameStart = 0;
      step(3);
      p0 = strobe;
      vblank = 1;
      readoutDone = 1;
      step(1);
      readoutDone = 0;
      step(2);
      p1 = strobe;
      step(W);
      resetDone = 1;
      step(1);
      resetDone = 0;
      step(2);
      p2 = strobe;
      step(W);
      vblank = 0;
      step(2);
   endtask
   function automatic logic [10:0] gainOf(input logic [15:0] f, input logic dig);
      logic [10:0] g;
      g = {4'h0, f[6:0]};
      for (int i = 7; i < (dig ? 11 : 9); i++)
         g = f[i] ? g << 1 : g;
      return g;
   endfunction

   initial
   begin
      logic [15:0] v;
      logic [15:0] oldG;
      void'($urandom(6));
      step(3);
      srst = 0;
      rdChk(8'h21, 16'h040c);
      rdChk(8'h23, 16'h0608);
      rdChk(8'h2b, 16'h0020);
      rdChk(8'h2c, 16'h0020);
      rdChk(8'h22, 16'h0000);
      wrReg(8'h23, 16'hc000);
      rdChk(8'h23, 16'h0000);
      for (int k = 0; k < 6; k++)
      begin
         v = (k == 0) ? 16'h0000 : 16'($urandom);
         contextB = k[0];
         {ctxBLowPower, ctxBColSkip, ctxBRowSkip} = 3'($urandom);
         wrReg(8'h21, v);
         frame();
         rowIndex = 11'h002 | 11'($urandom);
         colIndex = 11'h002 | 11'($urandom);
         step(2);
         chkBit(lowPower, contextB ? ctxBLowPower : v[10]);
         chkBit(rowKeep, !(contextB ? ctxBRowSkip : v[2]));
         chkBit(colKeep, !(contextB ? ctxBColSkip : v[3]));
         p0 = tick;
         step(1);
         chkBit(tick, lowPower ? !p0 : 1'b1);
         rdChk(8'h21, v & 16'h040c);
      end
      contextB = 0;
      oldG = 16'h0020;
      for (int k = 0; k < 4; k++)
      begin
         v = (k == 0) ? 16'h07ff : 16'($urandom);
         wrReg(8'h2b, v);
         wrReg(8'h2c, ~v);
         chk(16'(gT), 16'(gainOf(oldG, 1'b1)));
         frame();
         chk(16'(gA), 16'(gainOf(v, 1'b0)));
         chk(16'(gT), 16'(gainOf(v, 1'b1)));
         chk(16'(bT), 16'(gainOf(~v, 1'b1)));
         chk(16'(bA), 16'(gainOf(~v, 1'b0)));
         rdChk(8'h2c, ~v & 16'h07ff);
         oldG = v;
      end
      wrReg(8'h23, 16'h2c02);
      for (int k = 0; k < 5; k++)
      begin
         frame();
         chkBit(p2, k == 2);
         chkBit(p1, 1'b0);
      end
      chkNum(pulses, 1);
      chkNum(lastWidth, 2 * UNIT);
      chkBit(holdOne, 1'b1);
      wrReg(8'h23, 16'h0000);
      frame();
      chkBit(holdOne, 1'b0);
      wrReg(8'h23, 16'h2202);
      for (int k = 0; k < 4; k++)
      begin
         frame();
         chkBit(p1, k > 0);
         chkBit(p2, 1'b0);
      end
      chkNum(pulses, 4);
      wrReg(8'h23, 16'h0000);
      frame();
      wrReg(8'h23, 16'h0100);
      frame();
      frame();
      chkBit(p0, 1'b1);
      rdChk(8'h23, 16'h8100);
      wrReg(8'h23, 16'h0000);
      frame();
      chkBit(p0, 1'b1);
      chkBit(p1, 1'b0);
      rdChk(8'h23, 16'h0000);
      wrap_up();
   end
endmodule
`default_nettype wire
